/* File: rtl/sac_consts.svh */
`ifndef SAC_CONSTS_SVH
`define SAC_CONSTS_SVH
// register indices; byte address is index times four
`define SAC_IDX_IE 8'hA8
`define SAC_IDX_P3A 8'hB2
`define SAC_IDX_IP 8'hB8
`define SAC_IDX_REF 8'hC4
`define SAC_IDX_CTL 8'hC5
`define SAC_IDX_RH 8'hC6
`define SAC_IDX_RL 8'hC7
`define SAC_RST_IE 8'h00
`define SAC_RST_P3A 8'h00
`define SAC_RST_IP 8'h00
`define SAC_RST_REF 8'h00
`define SAC_RST_CTL 8'h00
`define SAC_RST_RH 8'h80
`define SAC_RST_RL 8'h00
`define SAC_CTL_PWR 7
`define SAC_CTL_CKS_HI 6
`define SAC_CTL_CKS_LO 5
`define SAC_CTL_DONE 4
`define SAC_CTL_START 3
`define SAC_CTL_CH_HI 2
`define SAC_IE_CONV 6
`define SAC_IE_GLOBAL 7
`define SAC_IP_CONV 6
`define SAC_CONV_CLKS 90
`endif

/* File: rtl/sac_pkg.sv */
package sac_pkg;
    typedef enum logic [1:0] {REF_SUPPLY, REF_INT24, REF_EXT, REF_RSVD} sac_ref_type;
    typedef enum logic [1:0] {ST_IDLE, ST_CONV, ST_DONE} sac_state_type;
    typedef struct packed {
        logic [7:0] ie;
        logic [7:0] p3a;
        logic [7:0] ip;
        logic [7:0] refc;
        logic [7:0] ctl;
        logic [7:0] rh;
        logic [7:0] rl;
    } sac_regs_type;
    typedef struct packed {
        logic [1:0] ratio;
        logic ena;
    } sac_div_type;
endpackage

/* File: rtl/sac_clkdiv.sv */
// Purpose: converter clock enable from pclk
// Assumes: ratio 0..3 = /1 /2 /4 /6
// Notes: one-cycle enable pulse, no derived clock
`include "sac_consts.svh"
module sac_clkdiv
    import sac_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire sac_div_type ctl,
    output logic tick
);
    typedef struct packed {
        logic [2:0] cnt;
        logic tick;
    } sac_dst_type;
    sac_dst_type st_r, st_nxt;
    logic [2:0] lim;

    always_comb begin
        case (ctl.ratio)
            2'h0: lim = 3'h0;
            2'h1: lim = 3'h1;
            2'h2: lim = 3'h3;
            default: lim = 3'h5;
        endcase
        st_nxt = st_r;
        st_nxt.tick = 1'b0;
        if (!ctl.ena) begin
            st_nxt.cnt = 3'h0;
        end else if (st_r.cnt >= lim) begin
            st_nxt.cnt = 3'h0;
            st_nxt.tick = 1'b1;
        end else begin
            st_nxt.cnt = st_r.cnt + 3'h1;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign tick = st_r.tick;

    chk_tick_spacing: assert property (@(posedge pclk) disable iff (!presetn)
        (st_r.tick && ctl.ena && ctl.ratio == 2'h3 && $stable(ctl.ratio)) |=> !st_r.tick [*5])
        else $error("divide by six tick too early");
endmodule

/* File: rtl/sac_adc_ctrl.sv */
// Purpose: control and register file of a shared 10-bit SAR converter
// Assumes: APB slave, byte address = printed offset * 4, analog core returns sar_data
// Notes: zero wait states; unmapped reads give zero with pslverr
`include "sac_consts.svh"
module sac_adc_ctrl
    import sac_pkg::*;
#(
    parameter int CONV_CLKS = `SAC_CONV_CLKS
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [9:0] sar_data,
    output logic [7:0] pin_analog_enable,
    output logic [7:0] analog_input_connect,
    output logic [1:0] reference_select,
    output logic converter_power_on,
    output logic converter_sample,
    output logic converter_irq_req,
    output logic converter_irq_high
);
    typedef struct packed {
        sac_regs_type regs;
        sac_state_type state;
        logic [6:0] cnt;
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
        logic [7:0] connect;
        logic sample;
        logic irq;
        logic irq_hi;
    } sac_st_type;

    sac_st_type st_r, st_nxt;
    logic tick;
    logic wr_en;
    logic rd_en;
    logic [7:0] wbyte;
    sac_div_type div;

    function automatic logic sel(input logic [11:0] a, input logic [7:0] idx);
        sel = (a == {2'h0, idx, 2'h0});
    endfunction

    assign wr_en = psel && penable && pwrite && pstrb[0];
    assign rd_en = psel && penable && !pwrite;
    assign wbyte = pwdata[7:0];
    // one driver for the whole carrier struct
    assign div = '{ratio: st_r.regs.ctl[`SAC_CTL_CKS_HI:`SAC_CTL_CKS_LO],
                   ena: st_r.regs.ctl[`SAC_CTL_PWR] && st_r.state == ST_CONV};

    sac_clkdiv u_div (
        .pclk(pclk),
        .presetn(presetn),
        .ctl(div),
        .tick(tick)
    );

    always_comb begin
        st_nxt = st_r;
        st_nxt.pready = 1'b0;
        st_nxt.pslverr = 1'b0;
        // register writes; the done flag only accepts writes that clear it
        if (wr_en) begin
            if (sel(paddr, `SAC_IDX_IE)) begin
                st_nxt.regs.ie = wbyte;
            end else if (sel(paddr, `SAC_IDX_P3A)) begin
                st_nxt.regs.p3a = wbyte;
            end else if (sel(paddr, `SAC_IDX_IP)) begin
                st_nxt.regs.ip = wbyte;
            end else if (sel(paddr, `SAC_IDX_REF)) begin
                st_nxt.regs.refc = {6'h00, wbyte[1:0]};
            end else if (sel(paddr, `SAC_IDX_CTL)) begin
                st_nxt.regs.ctl = wbyte;
                st_nxt.regs.ctl[`SAC_CTL_DONE] = st_r.regs.ctl[`SAC_CTL_DONE] & wbyte[`SAC_CTL_DONE];
            end else if (sel(paddr, `SAC_IDX_RH)) begin
                st_nxt.regs.rh = wbyte;
            end else if (sel(paddr, `SAC_IDX_RL)) begin
                st_nxt.regs.rl = {6'h00, wbyte[1:0]};
            end
        end
        // conversion sequencer
        st_nxt.sample = 1'b0;
        case (st_r.state)
            ST_IDLE: begin
                if (st_r.regs.ctl[`SAC_CTL_START] && st_r.regs.ctl[`SAC_CTL_PWR]) begin
                    st_nxt.state = ST_CONV;
                    st_nxt.cnt = 7'h0;
                    st_nxt.regs.ctl[`SAC_CTL_START] = 1'b0;
                end
            end
            ST_CONV: begin
                if (!st_r.regs.ctl[`SAC_CTL_PWR]) begin
                    st_nxt.state = ST_IDLE;
                end else if (tick) begin
                    st_nxt.cnt = st_r.cnt + 7'h1;
                    if (st_r.cnt == 7'(CONV_CLKS - 1)) begin
                        st_nxt.state = ST_DONE;
                        st_nxt.sample = 1'b1;
                    end
                end
            end
            default: begin
                // result loaded from sar_data in the sample cycle, at the edge that ends it
                st_nxt.regs.rh = sar_data[9:2];
                st_nxt.regs.rl = {6'h00, sar_data[1:0]};
                st_nxt.regs.ctl[`SAC_CTL_DONE] = 1'b1;
                st_nxt.state = ST_IDLE;
            end
        endcase
        // start written while busy stays pending; it is cleared only once taken
        if (!st_r.regs.ctl[`SAC_CTL_PWR] || !st_nxt.regs.ctl[`SAC_CTL_PWR]) begin
            st_nxt.connect = 8'h00;
        end else begin
            st_nxt.connect = 8'h00;
            st_nxt.connect[st_nxt.regs.ctl[`SAC_CTL_CH_HI:0]] = st_nxt.regs.p3a[st_nxt.regs.ctl[2:0]];
        end
        st_nxt.irq = st_nxt.regs.ctl[`SAC_CTL_DONE] && st_nxt.regs.ie[`SAC_IE_CONV];
        st_nxt.irq_hi = st_nxt.regs.ip[`SAC_IP_CONV];
        // read path
        st_nxt.prdata = 32'h0;
        if (psel && !penable) begin
            st_nxt.pready = 1'b1;
            if (!pwrite) begin
                if (sel(paddr, `SAC_IDX_IE)) begin
                    st_nxt.prdata[7:0] = st_r.regs.ie;
                end else if (sel(paddr, `SAC_IDX_P3A)) begin
                    st_nxt.prdata[7:0] = st_r.regs.p3a;
                end else if (sel(paddr, `SAC_IDX_IP)) begin
                    st_nxt.prdata[7:0] = st_r.regs.ip;
                end else if (sel(paddr, `SAC_IDX_REF)) begin
                    st_nxt.prdata[7:0] = st_r.regs.refc;
                end else if (sel(paddr, `SAC_IDX_CTL)) begin
                    st_nxt.prdata[7:0] = st_r.regs.ctl;
                end else if (sel(paddr, `SAC_IDX_RH)) begin
                    st_nxt.prdata[7:0] = st_r.regs.rh;
                end else if (sel(paddr, `SAC_IDX_RL)) begin
                    st_nxt.prdata[7:0] = st_r.regs.rl;
                end else begin
                    st_nxt.pslverr = 1'b1;
                end
            end else if (!(sel(paddr, `SAC_IDX_IE) || sel(paddr, `SAC_IDX_P3A) || sel(paddr, `SAC_IDX_IP)
                    || sel(paddr, `SAC_IDX_REF) || sel(paddr, `SAC_IDX_CTL) || sel(paddr, `SAC_IDX_RH)
                    || sel(paddr, `SAC_IDX_RL))) begin
                st_nxt.pslverr = 1'b1;
            end
        end else if (rd_en) begin
            st_nxt.prdata = st_r.prdata;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_r.regs.ie <= `SAC_RST_IE;
            st_r.regs.p3a <= `SAC_RST_P3A;
            st_r.regs.ip <= `SAC_RST_IP;
            st_r.regs.refc <= `SAC_RST_REF;
            st_r.regs.ctl <= `SAC_RST_CTL;
            st_r.regs.rh <= `SAC_RST_RH;
            st_r.regs.rl <= `SAC_RST_RL;
            st_r.state <= ST_IDLE;
            st_r.cnt <= 7'h0;
            st_r.prdata <= 32'h0;
            st_r.pready <= 1'b0;
            st_r.pslverr <= 1'b0;
            st_r.connect <= 8'h00;
            st_r.sample <= 1'b0;
            st_r.irq <= 1'b0;
            st_r.irq_hi <= 1'b0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign prdata = st_r.prdata;
    assign pready = st_r.pready;
    assign pslverr = st_r.pslverr;
    assign pin_analog_enable = st_r.regs.p3a;
    assign analog_input_connect = st_r.connect;
    assign reference_select = st_r.regs.refc[1:0];
    assign converter_power_on = st_r.regs.ctl[`SAC_CTL_PWR];
    assign converter_sample = st_r.sample;
    assign converter_irq_req = st_r.irq;
    assign converter_irq_high = st_r.irq_hi;

    chk_one_input: assert property (@(posedge pclk) disable iff (!presetn)
        $onehot0(analog_input_connect))
        else $error("more than one input connected");
    chk_power_off: assert property (@(posedge pclk) disable iff (!presetn)
        !converter_power_on |-> analog_input_connect == 8'h00)
        else $error("input connected while powered down");
    chk_done_set: assert property (@(posedge pclk) disable iff (!presetn)
        converter_sample |=> st_r.regs.ctl[`SAC_CTL_DONE] && st_r.regs.rh == $past(sar_data[9:2]))
        else $error("done flag or result not loaded after conversion");
    chk_start_clear: assert property (@(posedge pclk) disable iff (!presetn)
        (st_r.state == ST_IDLE && st_r.regs.ctl[`SAC_CTL_START] && converter_power_on)
        |=> st_r.state == ST_CONV && !st_r.regs.ctl[`SAC_CTL_START])
        else $error("start not taken or not cleared");
    chk_conv_len: assert property (@(posedge pclk) disable iff (!presetn)
        converter_sample |-> $past(st_r.cnt) == 7'(CONV_CLKS - 1))
        else $error("conversion length wrong");
    chk_irq_gate: assert property (@(posedge pclk) disable iff (!presetn)
        converter_irq_req |-> $past(st_nxt.regs.ie[`SAC_IE_CONV]) && $past(st_nxt.regs.ctl[`SAC_CTL_DONE]))
        else $error("interrupt request without enable and flag");
    chk_irq_prio: assert property (@(posedge pclk) disable iff (!presetn)
        converter_irq_high == $past(st_nxt.regs.ip[`SAC_IP_CONV]))
        else $error("priority does not follow register");
    chk_ref_sel: assert property (@(posedge pclk) disable iff (!presetn)
        reference_select == st_r.regs.refc[1:0] && st_r.regs.refc[7:2] == 6'h00)
        else $error("reference select mismatch");
    chk_done_hold: assert property (@(posedge pclk) disable iff (!presetn)
        (st_r.regs.ctl[`SAC_CTL_DONE] && !(wr_en && sel(paddr, `SAC_IDX_CTL))) |=> st_r.regs.ctl[`SAC_CTL_DONE])
        else $error("done flag cleared by hardware");
endmodule

/* File: dv/sac_analog_model.sv */
// Purpose: behavioural analog core behind the converter control
// Assumes: result taken at the edge that ends the converter_sample cycle
// Notes: code = {channel, reference, 5'h15}; toggles when not holding a result
module sac_analog_model (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic converter_sample,
    input wire logic converter_power_on,
    input wire logic [7:0] analog_input_connect,
    input wire logic [1:0] reference_select,
    output logic [9:0] sar_data
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [2:0] idx;
    logic [9:0] stale_r;
    always_comb begin
        idx = 3'h0;
        for (int i = 0; i < 8; i++) begin
            if (analog_input_connect[i]) begin
                idx = 3'(i);
            end
        end
    end
    // stale data is inverted so a late sample cannot pass by luck
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            stale_r <= 10'h155;
        end else begin
            stale_r <= ~stale_r;
        end
    end
    // result stands only while the sample pulse stands
    assign sar_data = (converter_sample && converter_power_on) ? {idx, reference_select, 5'h15} : stale_r;
endmodule

/* File: dv/testbench.sv */
// Purpose: self-checking bench of the converter control block
// Assumes: zero-wait APB slave, short conversion count
// Notes: pready sampled at the rising edge that completes the access
`include "sac_consts.svh"
module testbench
    import sac_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int CONV = 4;
    localparam logic [11:0] A_IE = {2'b00, `SAC_IDX_IE, 2'b00};
    localparam logic [11:0] A_P3A = {2'b00, `SAC_IDX_P3A, 2'b00};
    localparam logic [11:0] A_IP = {2'b00, `SAC_IDX_IP, 2'b00};
    localparam logic [11:0] A_REF = {2'b00, `SAC_IDX_REF, 2'b00};
    localparam logic [11:0] A_CTL = {2'b00, `SAC_IDX_CTL, 2'b00};
    localparam logic [11:0] A_RH = {2'b00, `SAC_IDX_RH, 2'b00};
    localparam logic [11:0] A_RL = {2'b00, `SAC_IDX_RL, 2'b00};
    typedef struct packed {logic [11:0] addr; logic wr; logic [7:0] wdata; logic [7:0] rdata;} sac_row_type;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, converter_power_on, converter_sample;
    logic converter_irq_req, converter_irq_high, e;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata;
    logic [9:0] sar_data;
    logic [7:0] pin_analog_enable, analog_input_connect, q;
    logic [1:0] reference_select;
    int fails, checked;
    sac_row_type rows [14];
    sac_adc_ctrl #(.CONV_CLKS(CONV)) dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(4'hF), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .sar_data(sar_data), .pin_analog_enable(pin_analog_enable),
        .analog_input_connect(analog_input_connect), .reference_select(reference_select),
        .converter_power_on(converter_power_on), .converter_sample(converter_sample),
        .converter_irq_req(converter_irq_req), .converter_irq_high(converter_irq_high));
    sac_analog_model model_u (.pclk(pclk), .presetn(presetn), .converter_sample(converter_sample),
        .converter_power_on(converter_power_on), .analog_input_connect(analog_input_connect),
        .reference_select(reference_select), .sar_data(sar_data));
    initial begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            fails++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic conclude();
        $display("checked=%0d fails=%0d", checked, fails);
        if (fails == 0 && checked > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    task automatic apb(input logic wr, input logic [11:0] a, input logic [7:0] d);
        int n;
        n = 0;
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= {24'h0, d};
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (pready !== 1'b1) begin
            fails++;
            conclude();
        end
        q = prdata[7:0];
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    // setup in the documented order, then one conversion
    task automatic conv(input logic [1:0] k, input logic [2:0] ch, input logic [1:0] rf, input logic irq);
        int n, d;
        logic [9:0] v;
        d = (k == 2'd0) ? 1 : (k == 2'd1) ? 2 : (k == 2'd2) ? 4 : 6;
        v = {ch, rf, 5'h15};
        n = 0;
        apb(1'b1, A_P3A, 8'hFF);
        apb(1'b1, A_REF, {6'h0, rf});
        apb(1'b1, A_CTL, {1'b0, k, 5'h00});
        apb(1'b1, A_CTL, {1'b1, k, 5'h00});
        apb(1'b1, A_CTL, {1'b1, k, 2'b00, ch});
        chk(pin_analog_enable, 8'hFF);
        chk(reference_select, rf);
        chk(converter_power_on, 1'b1);
        chk(analog_input_connect, 8'h01 << ch);
        apb(1'b1, A_CTL, {1'b1, k, 2'b01, ch});
        while (converter_sample !== 1'b1 && n < 400) begin
            @(negedge pclk);
            n++;
        end
        chk(32'(n + 3 >= (CONV - 1) * d && n <= (CONV + 1) * d + 3), 1);
        repeat (3) @(posedge pclk);
        apb(1'b0, A_RH, 8'h00);
        chk(q, v[9:2]);
        apb(1'b0, A_RL, 8'h00);
        chk(q, {6'h0, v[1:0]});
        apb(1'b0, A_CTL, 8'h00);
        chk(q, {1'b1, k, 2'b10, ch});
        chk(converter_irq_req, irq);
        apb(1'b1, A_CTL, {1'b1, k, 2'b00, ch});
        apb(1'b0, A_CTL, 8'h00);
        chk(q[4], 1'b0);
        chk(converter_irq_req, 1'b0);
        $display("conversion ratio %0d channel %0d done", k, ch);
    endtask
    initial begin
        {psel, penable, pwrite, presetn} = 4'h0;
        paddr = 12'h000;
        pwdata = 32'h0;
        fails = 0;
        checked = 0;
        rows = '{{A_IE, 1'b0, 8'h00, 8'h00}, {A_P3A, 1'b0, 8'h00, 8'h00}, {A_IP, 1'b0, 8'h00, 8'h00},
            {A_REF, 1'b0, 8'h00, 8'h00}, {A_CTL, 1'b0, 8'h00, 8'h00}, {A_RH, 1'b0, 8'h00, 8'h80},
            {A_RL, 1'b0, 8'h00, 8'h00}, {A_IE, 1'b1, 8'h40, 8'h40}, {A_P3A, 1'b1, 8'hA5, 8'hA5},
            {A_IP, 1'b1, 8'h40, 8'h40}, {A_REF, 1'b1, 8'hFF, 8'h03}, {A_RL, 1'b1, 8'hFF, 8'h03},
            {A_RH, 1'b1, 8'h5A, 8'h5A}, {12'h004, 1'b1, 8'hFF, 8'h00}};
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        foreach (rows[i]) begin
            if (rows[i].wr) begin
                apb(1'b1, rows[i].addr, rows[i].wdata);
            end
            apb(1'b0, rows[i].addr, 8'h00);
            chk(q, rows[i].rdata);
            chk(e, rows[i].addr == 12'h004);
        end
        $display("register table done");
        chk(converter_irq_high, 1'b1);
        chk(pin_analog_enable, 8'hA5);
        // channel 1 is digital in 0xA5, so no switch may close
        apb(1'b1, A_CTL, 8'h81);
        chk(analog_input_connect, 8'h00);
        for (int k = 0; k < 4; k++) begin
            conv(2'(k), 3'(2 * k + 1), 2'(k % 3), 1'b1);
        end
        apb(1'b1, A_IE, 8'h00);
        conv(2'd0, 3'd6, 2'd2, 1'b0);
        apb(1'b1, A_IP, 8'h00);
        chk(converter_irq_high, 1'b0);
        $display("masking done");
        // reset in mid-run must restore P3A, RH and CTL
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        chk(pin_analog_enable, 8'h00);
        apb(1'b0, A_RH, 8'h00);
        chk(q, 8'h80);
        apb(1'b0, A_CTL, 8'h00);
        chk(q, 8'h00);
        chk(converter_power_on, 1'b0);
        $display("mid-run reset done");
        conclude();
    end
endmodule
